/* File: src/sebf_dev.sv */
// eeprom front end: conditions, shifter, ack, decode
// assumes a link clock far faster than scl; storage is outside
//
// Chosen in sebf_host and sebf_pkg: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
module sebf_dev #(
  parameter int unsigned POR_CYCLES   = sebf_pkg::POR_CYCLES,
  parameter int unsigned WRITE_CYCLES = sebf_pkg::WRITE_CYCLES
) (
  // clock and reset
  input  wire logic                      LINK_CLK_I,
  input  wire logic                      RESETN_I,
  // two-wire link
  sebf_if.slave                          BUS,
  // pins
  input  wire logic                      STRAP_SELECT_BIT0_I,
  input  wire logic                      STRAP_SELECT_BIT1_I,
  input  wire logic                      STRAP_SELECT_BIT2_I,
  input  wire logic                      WRITE_PROTECT_PIN_I,
  // array side
  input  wire logic [7:0]                TX_DATA_I,
  output logic      [7:0]                RX_DATA_O,
  output logic                           RX_VALID_O,
  output logic                           RD_TAKE_O,
  output logic      [sebf_pkg::ADDR_W-1:0] WORD_ADDR_O,
  output sebf_pkg::sebf_area_t           AREA_O,
  output logic                           STANDBY_O,
  output logic                           PROG_BUSY_O,
  output logic                           INIT_BUSY_O
);
  localparam int unsigned NSYNC = 6;
  localparam int unsigned TMR_W = 32;

  if (POR_CYCLES < 1 || WRITE_CYCLES < 1) begin : g_chk
    $error("timer counts below one");
  end

  typedef enum logic [2:0] {
    D_INIT, D_STANDBY, D_DEVADDR, D_WORD0, D_WORD1, D_WDATA, D_RDATA, D_PROG
  } sebf_dstate_t;

  // pin synchroniser: {scl, sda, wp, strap2..0}
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  logic [NSYNC-1:0] pin_raw;
  logic             scl_q_reg;
  logic             sda_q_reg;
  logic             scl_s;
  logic             sda_s;
  logic             wp_s;
  logic [2:0]       strap_s;

  assign pin_raw = {BUS.scl, BUS.sda, WRITE_PROTECT_PIN_I, STRAP_SELECT_BIT2_I,
                    STRAP_SELECT_BIT1_I, STRAP_SELECT_BIT0_I};
  assign scl_s   = s2_reg[5];
  assign sda_s   = s2_reg[4];
  assign wp_s    = s2_reg[3];
  assign strap_s = s2_reg[2:0];

  always_ff @(posedge LINK_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      s1_reg    <= pin_raw;
      s2_reg    <= s1_reg;
      scl_q_reg <= scl_s;
      sda_q_reg <= sda_s;
    end
  end

  logic start_ev;
  logic stop_ev;
  logic rise_ev;
  logic fall_ev;
  assign start_ev = scl_s & scl_q_reg & sda_q_reg & ~sda_s; // R2 R1
  assign stop_ev  = scl_s & scl_q_reg & ~sda_q_reg & sda_s; // R3 R1
  assign rise_ev  = scl_s & ~scl_q_reg;
  assign fall_ev  = ~scl_s & scl_q_reg;

  sebf_dstate_t         st_reg, st_next;
  logic [3:0]           cnt_reg, cnt_next;
  logic [7:0]           sh_reg, sh_next;
  logic [7:0]           tx_reg, tx_next;
  logic                 drv_reg, drv_next;
  logic                 mack_reg, mack_next;
  logic                 rd_reg, rd_next;
  logic                 info_reg, info_next;
  logic                 wrote_reg, wrote_next;
  logic [TMR_W-1:0]     tmr_reg, tmr_next;
  logic [7:0]           rxd_reg, rxd_next;
  logic                 rxv_reg, rxv_next;
  logic                 take_reg, take_next;
  logic [sebf_pkg::ADDR_W-1:0] addr_reg, addr_next;
  sebf_pkg::sebf_area_t area_reg, area_next;

  logic [3:0] dev_type;
  logic       dev_match;
  assign dev_type  = sh_reg[sebf_pkg::DEV_TYPE_LSB +: 4];
  assign dev_match = (dev_type == sebf_pkg::DEV_TYPE_ARRAY
                      || dev_type == sebf_pkg::DEV_TYPE_INFO) // R7 R8
                     && sh_reg[sebf_pkg::STRAP_LSB +: 3] == strap_s; // R9

  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    sh_next    = sh_reg;
    tx_next    = tx_reg;
    drv_next   = drv_reg;
    mack_next  = mack_reg;
    rd_next    = rd_reg;
    info_next  = info_reg;
    wrote_next = wrote_reg;
    tmr_next   = tmr_reg;
    rxd_next   = rxd_reg;
    rxv_next   = 1'b0;
    take_next  = 1'b0;
    addr_next  = addr_reg;
    area_next  = area_reg;
    case (st_reg)
      D_INIT: begin
        // deaf until power-on time ends
        if (tmr_reg == TMR_W'(POR_CYCLES - 1)) begin // R15
          st_next  = D_STANDBY; // R5
          tmr_next = '0;
        end else begin
          tmr_next = tmr_reg + 1'b1;
        end
      end
      D_PROG: begin
        // all link activity ignored
        if (tmr_reg == TMR_W'(WRITE_CYCLES - 1)) begin // R17 R16
          st_next  = D_STANDBY; // R5
          tmr_next = '0;
        end else begin
          tmr_next = tmr_reg + 1'b1;
        end
      end
      default: begin
        if (start_ev) begin
          // any start re-arms, ending recovery too
          st_next  = D_DEVADDR; // R2 R6
          cnt_next = '0;
          drv_next = 1'b0;
        end else if (stop_ev) begin
          drv_next   = 1'b0;
          wrote_next = 1'b0;
          st_next    = wrote_reg ? D_PROG : D_STANDBY; // R16 R5 R3
          tmr_next   = '0;
        end else if (st_reg != D_STANDBY) begin
          if (rise_ev && cnt_reg <= 4'(sebf_pkg::BYTE_BITS)) begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg < 4'(sebf_pkg::BYTE_BITS)) begin
              sh_next = {sh_reg[6:0], sda_s}; // R18 R4
            end else begin
              mack_next = ~sda_s;
            end
          end
          if (fall_ev) begin
            if (cnt_reg == 4'(sebf_pkg::BYTE_BITS)) begin
              // ack driven after the eighth fall
              drv_next = 1'b1; // R4 R18
              case (st_reg)
                D_DEVADDR: begin
                  if (!dev_match) begin
                    st_next  = D_STANDBY; // R11
                    drv_next = 1'b0;
                  end
                  rd_next   = sh_reg[sebf_pkg::RW_BIT]; // R10
                  info_next = dev_type == sebf_pkg::DEV_TYPE_INFO; // R8
                end
                D_WORD0: begin
                  addr_next = {sh_reg[5:0], addr_reg[7:0]}; // R12
                  if (!info_reg) begin
                    area_next = sebf_pkg::AREA_ARRAY;
                  end else if (sh_reg[sebf_pkg::LOCK_SEL_BIT]) begin
                    area_next = sebf_pkg::AREA_LOCK;
                  end else if (sh_reg[sebf_pkg::SN_SEL_BIT]) begin
                    area_next = sebf_pkg::AREA_SERIAL;
                  end else begin
                    area_next = sebf_pkg::AREA_ID;
                  end
                end
                D_WORD1: begin
                  case (area_reg) // R13
                    sebf_pkg::AREA_ARRAY:  addr_next = {addr_reg[13:8], sh_reg};
                    sebf_pkg::AREA_ID:     addr_next = {8'h00, sh_reg[5:0]};
                    sebf_pkg::AREA_SERIAL: addr_next = {10'h000, sh_reg[3:0]};
                    default:               addr_next = '0;
                  endcase
                end
                D_WDATA: begin
                  if (area_reg == sebf_pkg::AREA_ARRAY && wp_s) begin
                    drv_next = 1'b0; // R14
                  end else begin
                    rxd_next   = sh_reg;
                    rxv_next   = 1'b1;
                    wrote_next = 1'b1;
                  end
                end
                default: drv_next = 1'b0;
              endcase
            end else if (cnt_reg > 4'(sebf_pkg::BYTE_BITS)) begin
              // ninth clock over: release
              cnt_next = '0;
              drv_next = 1'b0;
              case (st_reg)
                D_DEVADDR: st_next = rd_reg ? D_RDATA : D_WORD0; // R10
                D_WORD0:   st_next = D_WORD1;
                D_WORD1:   st_next = D_WDATA;
                D_RDATA:   st_next = mack_reg ? D_RDATA : D_STANDBY; // R5
                default:   st_next = st_reg;
              endcase
              if ((st_reg == D_DEVADDR && rd_reg) || (st_reg == D_RDATA && mack_reg)) begin
                drv_next  = ~TX_DATA_I[7]; // R18
                tx_next   = {TX_DATA_I[6:0], 1'b0};
                take_next = 1'b1;
              end
            end else if (st_reg == D_RDATA) begin
              drv_next = ~tx_reg[7]; // R18
              tx_next  = {tx_reg[6:0], 1'b0};
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge LINK_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_reg    <= D_INIT; // R15
      cnt_reg   <= '0;
      sh_reg    <= '0;
      tx_reg    <= '0;
      drv_reg   <= 1'b0;
      mack_reg  <= 1'b0;
      rd_reg    <= 1'b0;
      info_reg  <= 1'b0;
      wrote_reg <= 1'b0;
      tmr_reg   <= '0;
      rxd_reg   <= '0;
      rxv_reg   <= 1'b0;
      take_reg  <= 1'b0;
      addr_reg  <= '0;
      area_reg  <= sebf_pkg::AREA_ARRAY;
    end else begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      tx_reg    <= tx_next;
      drv_reg   <= drv_next;
      mack_reg  <= mack_next;
      rd_reg    <= rd_next;
      info_reg  <= info_next;
      wrote_reg <= wrote_next;
      tmr_reg   <= tmr_next;
      rxd_reg   <= rxd_next;
      rxv_reg   <= rxv_next;
      take_reg  <= take_next;
      addr_reg  <= addr_next;
      area_reg  <= area_next;
    end
  end

  assign BUS.sda_s_o  = 1'b0;
  assign BUS.sda_s_oe = drv_reg;
  assign RX_DATA_O    = rxd_reg;
  assign RX_VALID_O   = rxv_reg;
  assign RD_TAKE_O    = take_reg;
  assign WORD_ADDR_O  = addr_reg;
  assign AREA_O       = area_reg;
  assign STANDBY_O    = st_reg == D_STANDBY;
  assign PROG_BUSY_O  = st_reg == D_PROG;
  assign INIT_BUSY_O  = st_reg == D_INIT;
endmodule

/* File: src/sebf_pkg.sv */
// constants for the eeprom front end and its bus master
// assumes both ends meet through sebf_if; scl is made by the master
// Behaviour
// (R1) sda changes only while scl low
// (R2) sda falling with scl high is start
// (R3) sda rising with scl high is stop
// (R4) byte units; device acks on ninth clock
// (R5) standby after power-up, read stop, programming
// (R6) start, nine ones, start, stop resets
// (R7) device address 1010 for the array
// (R8) device address 1011 for id, lock, serial
// (R9) address bits 3..1 match straps, float low
// (R10) address bit 0: one read, zero write
// (R11) match acks low; mismatch returns to standby
// (R12) first word byte selects high address, area
// (R13) second word byte gives low address, offset
// (R14) write protect pin high blocks array writes
// (R15) no commands during 70 us initialisation
// (R16) write cycle counted from stop after write
// (R17) ignore inputs while write cycle runs
// (R18) sample on scl rise, drive after fall
package sebf_pkg;
  localparam logic [3:0] DEV_TYPE_ARRAY = 4'hA;
  localparam logic [3:0] DEV_TYPE_INFO  = 4'hB;
  localparam int unsigned DEV_TYPE_LSB  = 4;
  localparam int unsigned STRAP_LSB     = 1;
  localparam int unsigned RW_BIT        = 0;
  localparam int unsigned LOCK_SEL_BIT  = 2;
  localparam int unsigned SN_SEL_BIT    = 3;
  localparam int unsigned ADDR_W        = 14;
  localparam int unsigned ID_OFS_W      = 6;
  localparam int unsigned SN_OFS_W      = 4;
  localparam int unsigned BYTE_BITS     = 8;
  // link period in ps
  localparam longint LINK_PERIOD_PS              = 15000;
  localparam longint POWER_ON_INIT_TIME_US       = 70;
  localparam longint INTERNAL_WRITE_CYCLE_TIME_MS = 5;
  // least time rounds up, longest rounds down
  localparam int unsigned POR_CYCLES = int'((POWER_ON_INIT_TIME_US * 1000000
                                             + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
  localparam int unsigned WRITE_CYCLES = int'((INTERNAL_WRITE_CYCLE_TIME_MS
                                               * 1000000000) / LINK_PERIOD_PS);
  // scl quarter bit, at least 650 ns
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned SCL_QUARTER_NS = 650;
  localparam int unsigned QUARTER_CYCLES = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;
  // host registers
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int unsigned CMD_START = 8;
  localparam int unsigned CMD_STOP  = 9;
  localparam int unsigned CMD_READ  = 10;
  localparam int unsigned CMD_MACK  = 11;
  localparam int unsigned CMD_NOBYTE = 12;
  localparam int unsigned ST_BUSY   = 8;
  localparam int unsigned ST_NACK   = 9;
  typedef enum logic [1:0] {AREA_ARRAY, AREA_ID, AREA_LOCK, AREA_SERIAL} sebf_area_t;
endpackage

/* File: src/sebf_if.sv */
// two-wire link between the bus master and the eeprom front end
// both ends open-drain: oe high pulls sda low
`timescale 1ns/10ps
interface sebf_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic sda;
  // pulled up: low while any enabled driver is low
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport master (output scl, output sda_m_o, output sda_m_oe, input sda);
  modport slave  (input scl, input sda, output sda_s_o, output sda_s_oe);
endinterface

/* File: src/sebf_host.sv */
// two-wire bus master: a command register over ahb-lite
// assumes one ahb-lite master; scl divided from CLK_I
`timescale 1ns/10ps
module sebf_host #(
  parameter int unsigned QUARTER_CYCLES = sebf_pkg::QUARTER_CYCLES
) (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RESETN_I,
  // ahb-lite slave
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  // two-wire link
  sebf_if.master           BUS
);
  localparam int unsigned DIV_W = 16;
  if (QUARTER_CYCLES < 1 || QUARTER_CYCLES >= (1 << DIV_W)) begin : g_chk
    $error("QUARTER_CYCLES out of range");
  end

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} sebf_hstate_t;

  logic sda1_reg;
  logic sda2_reg;
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sda1_reg <= 1'b1;
      sda2_reg <= 1'b1;
    end else begin
      sda1_reg <= BUS.sda;
      sda2_reg <= sda1_reg;
    end
  end

  sebf_hstate_t     st_reg, st_next;
  logic [DIV_W-1:0] div_reg, div_next;
  logic [1:0]       ph_reg, ph_next;
  logic [3:0]       cnt_reg, cnt_next;
  logic [12:0]      cmd_reg, cmd_next;
  logic [7:0]       rx_reg, rx_next;
  logic             nack_reg, nack_next;
  logic             scl_reg, scl_next;
  logic             low_reg, low_next;
  logic             aw_reg, aw_next;
  logic [7:0]       aa_reg, aa_next;
  logic [31:0]      rd_reg, rd_next;
  logic             tick;
  logic             busy;

  assign tick = div_reg == DIV_W'(QUARTER_CYCLES - 1);
  assign busy = st_reg != H_IDLE;

  always_comb begin
    st_next   = st_reg;
    div_next  = tick ? '0 : div_reg + 1'b1;
    ph_next   = ph_reg;
    cnt_next  = cnt_reg;
    cmd_next  = cmd_reg;
    rx_next   = rx_reg;
    nack_next = nack_reg;
    scl_next  = scl_reg;
    low_next  = low_reg;
    aw_next   = 1'b0;
    aa_next   = aa_reg;
    rd_next   = rd_reg;
    // writes land in the data phase; dropped while busy
    if (HREADY_I && HSEL_I && HTRANS_I[1]) begin
      aw_next = HWRITE_I;
      aa_next = HADDR_I[7:0];
      rd_next = (HADDR_I[7:0] == sebf_pkg::REG_STATUS)
                ? {22'h000000, nack_reg, busy, rx_reg} : 32'h00000000;
    end
    if (aw_reg && aa_reg == sebf_pkg::REG_CMD && !busy) begin
      cmd_next = HWDATA_I[12:0];
      div_next = '0;
      ph_next  = '0;
      cnt_next = '0;
      if (HWDATA_I[sebf_pkg::CMD_START]) begin
        st_next = H_START; // R2 R7
      end else if (HWDATA_I[sebf_pkg::CMD_NOBYTE]) begin
        st_next = HWDATA_I[sebf_pkg::CMD_STOP] ? H_STOP : H_IDLE;
      end else begin
        st_next = H_BIT;
      end
    end else if (busy && tick) begin
      ph_next = ph_reg + 1'b1;
      case (st_reg)
        H_START: begin
          case (ph_reg)
            2'd0: low_next = 1'b0;
            2'd1: scl_next = 1'b1;
            2'd2: low_next = 1'b1; // R2
            default: begin
              scl_next = 1'b0;
              st_next  = cmd_reg[sebf_pkg::CMD_NOBYTE]
                         ? (cmd_reg[sebf_pkg::CMD_STOP] ? H_STOP : H_IDLE) : H_BIT;
            end
          endcase
        end
        H_BIT: begin
          case (ph_reg)
            // data moves only while scl low
            2'd0: low_next = (cnt_reg == 4'(sebf_pkg::BYTE_BITS))
                             ? (cmd_reg[sebf_pkg::CMD_READ] & ~cmd_reg[sebf_pkg::CMD_MACK])
                             : (~cmd_reg[sebf_pkg::CMD_READ] & ~cmd_reg[7]); // R1 R4
            2'd1: scl_next = 1'b1;
            2'd2: begin
              if (cnt_reg == 4'(sebf_pkg::BYTE_BITS)) begin
                nack_next = sda2_reg; // R4
              end else begin
                rx_next = {rx_reg[6:0], sda2_reg};
              end
            end
            default: begin
              scl_next = 1'b0;
              cnt_next = cnt_reg + 1'b1;
              cmd_next = {cmd_reg[12:8], cmd_reg[6:0], 1'b0};
              if (cnt_reg == 4'(sebf_pkg::BYTE_BITS)) begin
                low_next = 1'b0;
                st_next  = cmd_reg[sebf_pkg::CMD_STOP] ? H_STOP : H_IDLE;
              end
            end
          endcase
        end
        H_STOP: begin
          case (ph_reg)
            2'd0: low_next = 1'b1;
            2'd1: scl_next = 1'b1;
            2'd2: low_next = 1'b0; // R3
            default: st_next = H_IDLE;
          endcase
        end
        default: st_next = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_reg   <= H_IDLE;
      div_reg  <= '0;
      ph_reg   <= '0;
      cnt_reg  <= '0;
      cmd_reg  <= '0;
      rx_reg   <= '0;
      nack_reg <= 1'b0;
      scl_reg  <= 1'b1;
      low_reg  <= 1'b0;
      aw_reg   <= 1'b0;
      aa_reg   <= '0;
      rd_reg   <= '0;
    end else begin
      st_reg   <= st_next;
      div_reg  <= div_next;
      ph_reg   <= ph_next;
      cnt_reg  <= cnt_next;
      cmd_reg  <= cmd_next;
      rx_reg   <= rx_next;
      nack_reg <= nack_next;
      scl_reg  <= scl_next;
      low_reg  <= low_next;
      aw_reg   <= aw_next;
      aa_reg   <= aa_next;
      rd_reg   <= rd_next;
    end
  end

  assign BUS.scl      = scl_reg;
  assign BUS.sda_m_o  = 1'b0;
  assign BUS.sda_m_oe = low_reg;
  assign HRDATA_O     = rd_reg;
  assign HREADYOUT_O  = 1'b1;
  assign HRESP_O      = 1'b0;
endmodule

/* File: sim/sebf_monitor.sv */
// link checker: framing, ack placement, device timing
// assumes raw sebf_if signals, sampled by the link clock
`timescale 1ns/10ps
module sebf_monitor #(
  parameter int unsigned POR_CYCLES   = 50,
  parameter int unsigned WRITE_CYCLES = 200
) (
  // clock and reset
  input wire logic LINK_CLK_I,
  input wire logic RESETN_I,
  // link
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_oe,
  // device pins
  input wire logic STRAP_SELECT_BIT0_I,
  input wire logic STRAP_SELECT_BIT1_I,
  input wire logic STRAP_SELECT_BIT2_I,
  input wire logic STANDBY_O,
  input wire logic PROG_BUSY_O,
  input wire logic INIT_BUSY_O
);
  logic        scl_q, sda_q, first, rd, blk;
  logic [3:0]  cnt, sage;
  logic [7:0]  sh;
  logic [19:0] pcnt, icnt;
  wire         st   = scl & scl_q & sda_q & ~sda;
  wire         sp   = scl & scl_q & ~sda_q & sda;
  wire         ris  = scl & ~scl_q;
  wire         busy = INIT_BUSY_O | PROG_BUSY_O;
  wire         ack9 = ris & first & (cnt == 4'h8);
  wire         hit  = (sh[7:5] == 3'h5)
                    && (sh[3:1] == {STRAP_SELECT_BIT2_I, STRAP_SELECT_BIT1_I, STRAP_SELECT_BIT0_I});
  // blk: busy during the address byte leaves its ack open
  always_ff @(posedge LINK_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      {scl_q, sda_q, first, rd, blk, cnt, sage, sh, pcnt, icnt} <= '0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      pcnt  <= PROG_BUSY_O ? pcnt + 20'h1 : 20'h0;
      icnt  <= INIT_BUSY_O ? icnt + 20'h1 : 20'h0;
      sage  <= sp ? 4'h0 : sage + {3'h0, sage != 4'hF};
      blk   <= st ? busy : blk | busy;
      if (st) begin
        cnt   <= 4'h0;
        first <= 1'b1;
      end else if (ris) begin
        cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        if (cnt == 4'h8) begin
          first <= 1'b0;
        end else begin
          sh <= {sh[6:0], sda};
        end
        if (first && cnt == 4'h7) begin
          rd <= sda;
        end
      end
    end
  end
  default clocking cb @(posedge LINK_CLK_I);
  endclocking
  default disable iff (!RESETN_I);
  property p_move_low; $changed(sda_s_oe) |-> !scl && !$past(scl, 2); endproperty
  a_move_low: assert property (p_move_low) else $error("sda moved near scl high");
  property p_ack_ninth; ris && sda_s_oe && (first || !rd) |-> cnt == 4'h8; endproperty
  a_ack_ninth: assert property (p_ack_ninth) else $error("drive outside ack bit");
  property p_match_ack; ack9 && hit && !blk && !busy |-> sda_s_oe; endproperty
  a_match_ack: assert property (p_match_ack) else $error("match not acked");
  property p_miss_nack; ack9 && !hit |-> !sda_s_oe; endproperty
  a_miss_nack: assert property (p_miss_nack) else $error("foreign acked");
  property p_busy_quiet; busy |-> !sda_s_oe; endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("drove while busy");
  property p_read_stop; sp && rd |-> ##[0:6] STANDBY_O; endproperty
  a_read_stop: assert property (p_read_stop) else $error("no standby after read");
  property p_prog_entry; $rose(PROG_BUSY_O) |-> sage < 4'h8; endproperty
  a_prog_entry: assert property (p_prog_entry) else $error("write cycle without stop");
  property p_prog_len; $fell(PROG_BUSY_O) |-> pcnt == 20'(WRITE_CYCLES) && STANDBY_O; endproperty
  a_prog_len: assert property (p_prog_len) else $error("write cycle length");
  property p_init_len; $fell(INIT_BUSY_O) |-> icnt == 20'(POR_CYCLES) && STANDBY_O; endproperty
  a_init_len: assert property (p_init_len) else $error("init length");
  c_ack: cover property (ack9 && sda_s_oe);
  c_prog: cover property ($rose(PROG_BUSY_O));
  c_read_stop: cover property (sp && rd);
endmodule

/* File: sim/serial_eeprom_bus_front_end_test.sv */
// bench: ahb-lite master to host, host to device over sebf_if
// assumes a free link clock; straps and pins set here
`timescale 1ns/10ps
module serial_eeprom_bus_front_end_test;
  // short counts keep the run brief
  localparam int unsigned POR = 200;
  localparam int unsigned WRC = 2000;
  localparam logic [12:0] S  = 13'h1 << sebf_pkg::CMD_START;
  localparam logic [12:0] P  = 13'h1 << sebf_pkg::CMD_STOP;
  localparam logic [12:0] RD = 13'h1 << sebf_pkg::CMD_READ;
  localparam logic [12:0] MK = 13'h1 << sebf_pkg::CMD_MACK;
  localparam logic [12:0] NB = 13'h1 << sebf_pkg::CMD_NOBYTE;
  typedef struct {
    logic [2:0]  e;
    logic [7:0]  a, w0, w1;
    logic        nk;
    logic [1:0]  ar;
    logic [13:0] wa;
  } sebf_row_t;
  logic        clk, lclk, rstn, hsel, hwrite, hready, hresp, wp, rxv, rdt, stby, pbusy, ibusy;
  logic [1:0]  htrans;
  logic [2:0]  hsize, e;
  logic [7:0]  txd, rxd;
  logic [13:0] wa;
  logic [31:0] haddr, hwdata, hrdata, st;
  int          n_mismatch = 0, n_checks = 0, nrx = 0, ntk = 0, cyc = 0;
  sebf_pkg::sebf_area_t area;
  wire logic   nck = st[sebf_pkg::ST_NACK];
  sebf_row_t   rows [10] = '{
    '{3'h0, 8'hA0, 8'hC5, 8'h7E, 1'h0, 2'h0, 14'h057E},
    '{3'h5, 8'hAA, 8'h3F, 8'h01, 1'h0, 2'h0, 14'h3F01},
    '{3'h2, 8'hA4, 8'h12, 8'h34, 1'h0, 2'h0, 14'h1234},
    '{3'h0, 8'hB0, 8'h00, 8'hFF, 1'h0, 2'h1, 14'h0},
    '{3'h0, 8'hB0, 8'h04, 8'h00, 1'h0, 2'h2, 14'h0},
    '{3'h0, 8'hB0, 8'h0C, 8'h00, 1'h0, 2'h2, 14'h0},
    '{3'h0, 8'hB0, 8'h08, 8'h0F, 1'h0, 2'h3, 14'h0},
    '{3'h0, 8'h90, 8'h00, 8'h00, 1'h1, 2'h0, 14'h0},
    '{3'h0, 8'hA2, 8'h00, 8'h00, 1'h1, 2'h0, 14'h0},
    '{3'h5, 8'hA0, 8'h00, 8'h00, 1'h1, 2'h0, 14'h0}};
  sebf_if bus ();
  sebf_host #(.QUARTER_CYCLES(4)) sebf_host_inst (.CLK_I(clk), .RESETN_I(rstn),
    .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .BUS(bus));
  sebf_dev #(.POR_CYCLES(POR), .WRITE_CYCLES(WRC)) sebf_dev_inst (.LINK_CLK_I(lclk),
    .RESETN_I(rstn), .BUS(bus), .STRAP_SELECT_BIT0_I(e[0]), .STRAP_SELECT_BIT1_I(e[1]),
    .STRAP_SELECT_BIT2_I(e[2]), .WRITE_PROTECT_PIN_I(wp), .TX_DATA_I(txd), .RX_DATA_O(rxd),
    .RX_VALID_O(rxv), .RD_TAKE_O(rdt), .WORD_ADDR_O(wa), .AREA_O(area), .STANDBY_O(stby),
    .PROG_BUSY_O(pbusy), .INIT_BUSY_O(ibusy));
  sebf_monitor #(.POR_CYCLES(POR), .WRITE_CYCLES(WRC)) sebf_monitor_inst (.LINK_CLK_I(lclk),
    .RESETN_I(rstn), .scl(bus.scl), .sda(bus.sda), .sda_s_oe(bus.sda_s_oe),
    .STRAP_SELECT_BIT0_I(e[0]), .STRAP_SELECT_BIT1_I(e[1]), .STRAP_SELECT_BIT2_I(e[2]),
    .STANDBY_O(stby), .PROG_BUSY_O(pbusy), .INIT_BUSY_O(ibusy));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #3.3;
    forever #7.5 lclk = ~lclk;
  end
  always @(posedge lclk) begin
    if (rxv === 1'b1) nrx++;
    if (rdt === 1'b1) ntk++;
  end
  // run is near 7000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    st = hrdata;
  endtask
  // next command only once busy clears
  task automatic cmd(input logic [12:0] c);
    xfer(sebf_pkg::REG_CMD, 1'b1, {19'h0, c});
    do xfer(sebf_pkg::REG_STATUS, 1'b0, 32'h0); while (st[sebf_pkg::ST_BUSY] !== 1'b0);
  endtask
  initial begin
    {hsel, hwrite, wp, rstn} = 4'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    e = 3'h0;
    txd = 8'h00;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("init busy", 32'(ibusy), 32'h1);
    cmd(S | 13'h00A0);
    chk("init nack", 32'(nck), 32'h1);
    cmd(P | NB);
    chk("init standby", 32'(stby), 32'h1);
    $display("end reset");
    foreach (rows[i]) begin
      e <= rows[i].e;
      cmd(S | 13'(rows[i].a));
      chk("addr nack", 32'(nck), 32'(rows[i].nk));
      if (!rows[i].nk) begin
        cmd(13'(rows[i].w0));
        cmd(13'(rows[i].w1));
        chk("area", 32'(area), 32'(rows[i].ar));
        if (rows[i].ar == 2'h0) chk("word addr", 32'(wa), 32'(rows[i].wa));
      end
      cmd(P | NB);
      $display("end row %0d", i);
    end
    e <= 3'h0;
    wp <= 1'b1;
    cmd(S | 13'h00A0);
    cmd(13'h0001);
    cmd(13'h0002);
    cmd(13'h003C);
    chk("protected nack", 32'(nck), 32'h1);
    cmd(P | NB);
    wp <= 1'b0;
    cmd(S | 13'h00A0);
    chk("no write cycle", 32'(nck), 32'h0);
    cmd(13'h0001);
    cmd(13'h0002);
    cmd(13'h003C);
    chk("data nack", 32'(nck), 32'h0);
    chk("rx data", 32'(rxd), 32'h3C);
    chk("rx count", nrx, 32'h1);
    cmd(P | NB);
    cmd(S | 13'h00A0);
    chk("busy nack", 32'(nck), 32'h1);
    chk("prog busy", 32'(pbusy), 32'h1);
    cmd(P | NB);
    while (stby !== 1'b1) @(posedge clk);
    chk("prog done", 32'(pbusy), 32'h0);
    $display("end write");
    txd <= 8'hC3;
    cmd(S | 13'h00A1);
    chk("read nack", 32'(nck), 32'h0);
    cmd(RD | MK | P);
    chk("read byte", {24'h0, st[7:0]}, 32'hC3);
    chk("take count", ntk, 32'h1);
    chk("read standby", 32'(stby), 32'h1);
    $display("end read");
    cmd(S | 13'h00A0);
    cmd(13'h0011);
    cmd(S | 13'h00FF);
    chk("ones nack", 32'(nck), 32'h1);
    cmd(S | P | NB);
    chk("reset standby", 32'(stby), 32'h1);
    cmd(S | 13'h00A0);
    chk("after reset", 32'(nck), 32'h0);
    cmd(P | NB);
    $display("end soft reset");
    print_verdict();
  end
endmodule
